// *** dv/mmtw_bus_peer.sv ***
// Remote bus party: drives protocol engine events for the data path
`timescale 1ns/1ps
`default_nettype none
module mmtw_bus_peer (
  // Clock
  input wire logic clk_i,
  // Engine events
  output logic start_det_o,
  output logic stop_det_o,
  output logic addr_done_o,
  output logic addr_match_o,
  output logic addr_read_o,
  output logic byte_done_o,
  output logic [7:0] rx_byte_o,
  output logic is_rx_o,
  output logic ack_seen_o,
  output logic arb_lost_o
);
  initial begin
    {start_det_o, stop_det_o, addr_done_o, byte_done_o, arb_lost_o} = '0;
    {addr_match_o, addr_read_o, is_rx_o, ack_seen_o} = '0;
    rx_byte_o = 8'h00;
  end
  ////////////////////////////////////////
  // Bus condition: 0 start, 1 stop, 2 arbitration lost
  task automatic cond(input int k);
    @(posedge clk_i);
    start_det_o <= (k == 0);
    stop_det_o <= (k == 1);
    arb_lost_o <= (k == 2);
    @(posedge clk_i);
    {start_det_o, stop_det_o, arb_lost_o} <= 3'b000;
  endtask
  // Byte end with ack slot; qualifiers scrambled once the slot is over
  task automatic xfer(input logic adr, input logic m, input logic rd, input logic rx,
                      input logic ack, input logic [7:0] b);
    @(posedge clk_i);
    addr_done_o <= adr;
    byte_done_o <= !adr;
    {addr_match_o, addr_read_o, is_rx_o, ack_seen_o} <= {m, rd, rx, ack};
    rx_byte_o <= b;
    @(posedge clk_i);
    {addr_done_o, byte_done_o} <= 2'b00;
    {addr_match_o, addr_read_o, is_rx_o, ack_seen_o} <= ~{m, rd, rx, ack};
    rx_byte_o <= ~b;
  endtask
endmodule
`default_nettype wire

// *** dv/tb_multimaster_smbus_data_path.sv ***
// Testbench: registers, hand-off, receive, CRC, divider and bus release
`timescale 1ns/1ps
`default_nettype none
module tb_multimaster_smbus_data_path
  import mmtw_pkg::*;
;
  localparam logic [5:0] A_TX = {2'b00, ADDR_TX_HOLDING_BYTE};
  localparam logic [5:0] A_RX = {2'b00, ADDR_RX_HOLDING_BYTE};
  localparam logic [5:0] A_CRC = {2'b00, ADDR_CRC_RESULT_BYTE};
  localparam logic [5:0] A_DIV = {2'b00, ADDR_BIT_RATE_DIVIDER};
  localparam logic [31:0] TXE = 32'h1 << ST_TX_EMPTY_BIT;
  localparam logic [31:0] RXF = 32'h1 << ST_RX_FULL_BIT;
  localparam logic [31:0] TXV = 32'h1 << ST_TX_EVENT_BIT;
  localparam logic [31:0] RXV = 32'h1 << ST_RX_EVENT_BIT;
  localparam logic [31:0] CRR = 32'h1 << ST_CRC_READY_BIT;
  localparam logic [31:0] BSY = 32'h1 << ST_BUSY_BIT;
  localparam logic [31:0] ARB = 32'h1 << ST_ARB_LOST_BIT;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic wb_cyc_i = 1'b0;
  logic wb_stb_i = 1'b0;
  logic wb_we_i = 1'b0;
  logic [5:0] wb_adr_i = 6'h00;
  logic [3:0] wb_sel_i = 4'h0;
  logic [31:0] wb_dat_i = 32'h0;
  logic [3:0] sel_v = 4'hf;
  logic [31:0] wb_dat_o;
  logic wb_ack_o, shift_load_o, gen_stop_o, sda_release_o, scl_release_o, bit_tick_o;
  logic [7:0] shift_byte_o, rx_byte_i;
  logic start_det_i, stop_det_i, addr_done_i, addr_match_i, addr_read_i;
  logic byte_done_i, is_rx_i, ack_seen_i, arb_lost_i;
  int mismatches = 0;
  int checks_done = 0;
  int stops = 0;
  int cyc_n = 0;
  int last_tick = 0;
  int tick_gap = 0;
  logic [7:0] load_q[$];

  always #20 clk_i = ~clk_i;

  mmtw_data_path dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .start_det_i(start_det_i),
    .stop_det_i(stop_det_i), .addr_done_i(addr_done_i), .addr_match_i(addr_match_i),
    .addr_read_i(addr_read_i), .byte_done_i(byte_done_i), .rx_byte_i(rx_byte_i),
    .is_rx_i(is_rx_i), .ack_seen_i(ack_seen_i), .arb_lost_i(arb_lost_i),
    .shift_load_o(shift_load_o), .shift_byte_o(shift_byte_o), .gen_stop_o(gen_stop_o),
    .sda_release_o(sda_release_o), .scl_release_o(scl_release_o), .bit_tick_o(bit_tick_o));
  mmtw_bus_peer peer (.clk_i(clk_i), .start_det_o(start_det_i), .stop_det_o(stop_det_i),
    .addr_done_o(addr_done_i), .addr_match_o(addr_match_i), .addr_read_o(addr_read_i),
    .byte_done_o(byte_done_i), .rx_byte_o(rx_byte_i), .is_rx_o(is_rx_i),
    .ack_seen_o(ack_seen_i), .arb_lost_o(arb_lost_i));
  ////////////////////////////////////////
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    checks_done++;
    if (got !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t %s: got %h expected %h", $time, what, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic wb(input logic w, input logic [5:0] a, input logic [31:0] d,
                    output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk_i);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    wb_sel_i <= sel_v;
    do begin
      @(posedge clk_i);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 50);
    q = wb_dat_o;
    chk(32'(n < 50), 32'h1, "bus answer");
    @(posedge clk_i);
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i <= 1'b0;
  endtask
  task automatic wr(input logic [5:0] a, input logic [31:0] d);
    logic [31:0] q;
    wb(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [5:0] a, input logic [31:0] m, input logic [31:0] e,
                    input string what);
    logic [31:0] q;
    wb(1'b0, a, 32'h0, q);
    chk(q & m, e, what);
  endtask
  task automatic wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask
  function automatic logic [7:0] crc8(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    return r;
  endfunction
  ////////////////////////////////////////
  // Shifter loads checked against the expected queue
  always @(posedge clk_i) begin
    cyc_n++;
    if (!rst_i && shift_load_o === 1'b1) begin
      if (load_q.size() == 0) chk(32'h1, 32'h0, "unexpected shifter load");
      else chk(shift_byte_o, load_q.pop_front(), "shifter byte");
    end
    if (gen_stop_o === 1'b1) stops++;
    if (bit_tick_o === 1'b1) begin
      tick_gap = cyc_n - last_tick;
      last_tick = cyc_n;
    end
  end
  initial begin
    wt(60000);
    chk(32'h1, 32'h0, "watchdog expired");
    end_sim();
  end
  initial begin
    logic [7:0] b, c;
    logic [31:0] q;
    int s;
    s = $urandom(32'h59b9051d);
    wt(10);
    rst_i <= 1'b0;
    rd(ADDR_STATUS, ALL, 32'h101, "status reset");
    rd(A_DIV, ALL, 32'h0, "divider reset");
    rd(6'h3c, ALL, 32'h0, "unmapped read");
    wr(6'h3c, 32'hff);
    wr(A_DIV, 32'hffff_ff05);
    rd(A_DIV, ALL, 32'h5, "divider width");
    sel_v = 4'($urandom) & 4'he;
    wr(A_DIV, 32'h3);
    sel_v = 4'hf;
    rd(A_DIV, ALL, 32'h5, "lane 0 off ignored");
    wr(A_TX, 32'h1a5);
    rd(A_TX, ALL, 32'ha5, "tx holding width");
    $display("test registers done");
    wr(ADDR_CONTROL, 32'h1);
    for (int k = 0; k < 8; k++) begin
      wr(A_DIV, 32'(k));
      wt((20 << k) * 3 + 2600);
      chk(tick_gap, 32'(BASE_DIVISOR << k), "tick period");
    end
    wr(A_DIV, 32'h5);
    wt(2000);
    chk(32'(CLK_KHZ / tick_gap inside {[MIN_RATE_KHZ:MAX_RATE_KHZ]}), 32'h1, "bit rate");
    $display("test divider done");
    wr(ADDR_CONTROL, 32'h3);
    peer.cond(0);
    b = 8'($urandom);
    wr(A_TX, b);
    rd(ADDR_STATUS, TXE, 32'h0, "empty after write");
    load_q.push_back(b);
    peer.xfer(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'($urandom));
    wt(3);
    rd(ADDR_STATUS, TXE | TXV, TXE | TXV, "handoff flags");
    b = 8'($urandom);
    wr(A_TX, b);
    load_q.push_back(b);
    peer.xfer(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    b = 8'($urandom);
    wr(A_TX, b);
    peer.xfer(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    wt(3);
    chk(stops, 32'h1, "stop request");
    chk(load_q.size(), 32'h0, "master loads");
    rd(ADDR_STATUS, TXE, 32'h0, "empty kept clear");
    peer.cond(1);
    $display("test master transmit done");
    wr(ADDR_CONTROL, 32'h1);
    peer.cond(0);
    load_q.push_back(b);
    peer.xfer(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'($urandom));
    b = 8'($urandom);
    wr(A_TX, b);
    load_q.push_back(b);
    peer.xfer(1'b0, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    b = 8'($urandom);
    wr(A_TX, b);
    chk(sda_release_o, 32'h0, "sda driven");
    peer.xfer(1'b0, 1'b0, 1'b0, 1'b0, 1'b0, 8'h00);
    wt(3);
    chk(sda_release_o, 32'h1, "sda released");
    rd(ADDR_STATUS, TXE, 32'h0, "slave empty kept clear");
    chk(load_q.size(), 32'h0, "slave loads");
    peer.cond(1);
    peer.cond(0);
    load_q.push_back(b);
    peer.xfer(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h00);
    wt(3);
    chk(load_q.size(), 32'h0, "pending byte on new call");
    peer.cond(1);
    $display("test slave transmit done");
    wb(1'b0, A_RX, 32'h0, q);
    wr(ADDR_STATUS, 32'h0);
    peer.cond(0);
    c = 8'($urandom);
    peer.xfer(1'b1, 1'b1, 1'b0, 1'b1, 1'b1, c);
    wt(3);
    rd(A_RX, ALL, c, "address shown");
    b = 8'($urandom);
    peer.xfer(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, b);
    wt(3);
    rd(ADDR_STATUS, RXF | RXV, RXF | RXV, "rx flags");
    peer.xfer(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, ~b);
    wt(3);
    rd(A_RX, ALL, b, "byte held while full");
    rd(ADDR_STATUS, RXF, 32'h0, "full cleared");
    b = 8'($urandom);
    peer.xfer(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, b);
    wt(3);
    rd(A_RX, ALL, b, "next byte");
    peer.cond(1);
    $display("test receive done");
    wr(ADDR_CONTROL, 32'h7);
    peer.cond(0);
    b = 8'($urandom);
    peer.xfer(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, b);
    c = crc8(8'h00, b);
    wt(3);
    rd(ADDR_STATUS, CRR, CRR, "crc ready");
    rd(A_RX, ALL, b, "master rx");
    b = 8'($urandom);
    peer.xfer(1'b0, 1'b0, 1'b0, 1'b1, 1'b1, b);
    c = crc8(c, b);
    wt(3);
    rd(A_CRC, ALL, c, "crc value");
    rd(ADDR_STATUS, CRR, 32'h0, "crc ready cleared");
    wr(ADDR_CONTROL, 32'h3);
    wr(A_TX, c);
    load_q.push_back(c);
    peer.cond(0);
    peer.xfer(1'b1, 1'b0, 1'b0, 1'b0, 1'b1, 8'h00);
    wt(3);
    chk(load_q.size(), 32'h0, "crc byte sent");
    $display("test crc done");
    peer.cond(2);
    wt(2);
    chk({sda_release_o, scl_release_o}, 32'h3, "lines released");
    rd(ADDR_STATUS, ARB, ARB, "arbitration flag");
    $display("test arbitration done");
    wr(ADDR_CONTROL, 32'h1);
    peer.cond(0);
    wt(2);
    rd(ADDR_STATUS, BSY, BSY, "busy set");
    wr(ADDR_CONTROL, 32'h0);
    rd(ADDR_STATUS, BSY, 32'h0, "busy cleared");
    chk({sda_release_o, scl_release_o}, 32'h3, "bus released");
    wr(ADDR_CONTROL, 32'h1);
    b = 8'($urandom);
    wr(A_TX, b);
    load_q.push_back(b);
    peer.cond(0);
    peer.xfer(1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 8'h00);
    wt(3);
    chk(load_q.size(), 32'h0, "resumed");
    $display("test enable done");
    end_sim();
  end
endmodule
`default_nettype wire

// *** rtl/mmtw_crc8.sv ***
// Byte-wide CRC-8 update for the packet error code
`timescale 1ns/1ps
`default_nettype none
module mmtw_crc8
  import mmtw_pkg::*;
(
  // Inputs
  input wire logic [7:0] crc_i,
  input wire logic [7:0] data_i,
  // Result
  output logic [7:0] crc_o
);

  function automatic logic [7:0] crc_step(input logic [7:0] c, input logic [7:0] d);
    logic [7:0] r;
    r = c ^ d;
    for (int i = 0; i < 8; i++) begin
      r = r[7] ? ((r << 1) ^ CRC_POLY) : (r << 1);
    end
    return r;
  endfunction

  assign crc_o = crc_step(crc_i, data_i);

endmodule
`default_nettype wire

// *** rtl/mmtw_data_path.sv ***
// Two-wire controller data path: holding registers, CRC, divider and bus release
// Behaviour
// - Slave read after own address match loads holding byte into shifter.
// - Slave transmit: acked byte done loads next holding byte.
// - Slave transmit nack: release SDA, keep byte, empty flag stays clear.
// - Master write: holding byte loads after address acknowledged.
// - Master transmit: acked byte done loads next holding byte.
// - Master transmit byte nack: stop request, no load, empty flag clear.
// - Receive register: address while matched in slave, else last byte.
// - Reading receive register clears full flag, lets next byte load.
// - Each receive register load sets receive event flag.
// - Each data byte moved produces CRC byte, loaded, ready flag set.
// - Reading CRC register clears ready flag.
// - Unread CRC result overwritten on next load; ready flag stays set.
// - Three-bit select picks divisor 20 to 2560 for bit rate.
// - Arbitration loss as master releases SDA and SCL at once.
// - Clearing enable releases bus and clears busy; setting resumes.
// - Empty flag set on handoff to shifter, cleared on CPU write.
// - Transmit event flag set when holding byte handed to shifter.
`timescale 1ns/1ps
`default_nettype none
module mmtw_data_path
  import mmtw_pkg::*;
#(
  parameter int DIV_W = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [5:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Protocol engine events
  input wire logic start_det_i,
  input wire logic stop_det_i,
  input wire logic addr_done_i,
  input wire logic addr_match_i,
  input wire logic addr_read_i,
  input wire logic byte_done_i,
  input wire logic [7:0] rx_byte_i,
  input wire logic is_rx_i,
  input wire logic ack_seen_i,
  input wire logic arb_lost_i,
  // Shifter and line control
  output logic shift_load_o,
  output logic [7:0] shift_byte_o,
  output logic gen_stop_o,
  output logic sda_release_o,
  output logic scl_release_o,
  output logic bit_tick_o
);

  typedef struct packed {
    logic [7:0] tx_holding_byte;
    logic [7:0] rx_holding_byte;
    logic [7:0] rx_addr;
    logic [7:0] crc_result_byte;
    logic [7:0] crc_acc;
    logic [2:0] divider_select;
    logic module_enable;
    logic master_mode;
    logic master_direction;
    logic tx_holding_empty;
    logic rx_holding_full;
    logic tx_event_flag;
    logic rx_event_flag;
    logic crc_ready_flag;
    logic bus_busy_flag;
    logic own_address_matched;
    logic slave_direction;
    logic ack_not_received;
    logic arb_lost;
    logic hold_tx;
    logic shift_load;
    logic [7:0] shift_byte;
    logic gen_stop;
    logic release_lines;
    logic ack;
    logic [31:0] rdata;
  } mmtw_st_t;

  mmtw_st_t st;
  mmtw_st_t next_st;
  logic [7:0] crc_next;
  logic [7:0] crc_data;
  logic req;
  logic wr;
  logic rd;
  logic handoff;

  ////////////////////////////////////////////////////////////////////////////
  // Helpers

  mmtw_crc8 u_crc (
    .crc_i(st.crc_acc),
    .data_i(crc_data),
    .crc_o(crc_next)
  );

  mmtw_rate_div #(.CNT_W(DIV_W)) u_div (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .run_i(st.module_enable),
    .sel_i(st.divider_select),
    .tick_o(bit_tick_o)
  );

  assign crc_data = is_rx_i ? rx_byte_i : st.shift_byte;
  assign req = wb_cyc_i && wb_stb_i && !st.ack;
  assign wr = req && wb_we_i && wb_sel_i[0];
  assign rd = req && !wb_we_i;

  // Handoff conditions for holding byte
  always_comb begin
    handoff = 1'b0;
    if (st.module_enable && !st.tx_holding_empty) begin
      if (!st.master_mode && addr_done_i && addr_match_i && addr_read_i) begin
        handoff = 1'b1;
      end else if (!st.master_mode && byte_done_i && !is_rx_i && ack_seen_i
                   && st.slave_direction && !st.hold_tx) begin
        handoff = 1'b1;
      end else if (st.master_mode && !st.master_direction && addr_done_i && ack_seen_i) begin
        handoff = 1'b1;
      end else if (st.master_mode && byte_done_i && !is_rx_i && ack_seen_i) begin
        handoff = 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next state

  always_comb begin
    next_st = st;
    next_st.shift_load = 1'b0;
    next_st.gen_stop = 1'b0;
    next_st.ack = req;
    if (req) begin
      unique case (wb_adr_i)
        {2'b00, ADDR_TX_HOLDING_BYTE}: next_st.rdata = {24'h0, st.tx_holding_byte};
        {2'b00, ADDR_RX_HOLDING_BYTE}: next_st.rdata = {24'h0,
          (!st.master_mode && st.own_address_matched) ? st.rx_addr
                                                       : st.rx_holding_byte};
        {2'b00, ADDR_CRC_RESULT_BYTE}: next_st.rdata = {24'h0, st.crc_result_byte};
        {2'b00, ADDR_BIT_RATE_DIVIDER}: next_st.rdata = {29'h0, st.divider_select};
        ADDR_CONTROL: next_st.rdata = {29'h0, st.master_direction, st.master_mode,
                                       st.module_enable};
        ADDR_STATUS: next_st.rdata = {22'h0, st.arb_lost, st.ack_not_received,
          st.slave_direction, st.own_address_matched, st.bus_busy_flag,
          st.crc_ready_flag, st.rx_event_flag, st.tx_event_flag,
          st.rx_holding_full, st.tx_holding_empty};
        default: next_st.rdata = 32'h0;
      endcase
    end
    // Register writes
    if (wr) begin
      unique case (wb_adr_i)
        {2'b00, ADDR_TX_HOLDING_BYTE}: begin
          next_st.tx_holding_byte = wb_dat_i[7:0];
          next_st.tx_holding_empty = 1'b0;
        end
        {2'b00, ADDR_BIT_RATE_DIVIDER}: next_st.divider_select = wb_dat_i[2:0];
        ADDR_CONTROL: begin
          next_st.module_enable = wb_dat_i[CTL_ENABLE_BIT];
          next_st.master_mode = wb_dat_i[CTL_MASTER_BIT];
          next_st.master_direction = wb_dat_i[CTL_DIR_BIT];
        end
        ADDR_STATUS: begin
          if (!wb_dat_i[ST_TX_EVENT_BIT]) next_st.tx_event_flag = 1'b0;
          if (!wb_dat_i[ST_RX_EVENT_BIT]) next_st.rx_event_flag = 1'b0;
          if (!wb_dat_i[ST_ARB_LOST_BIT]) next_st.arb_lost = 1'b0;
        end
        default: begin
        end
      endcase
    end
    // Reads with side effects
    if (rd && wb_adr_i == {2'b00, ADDR_RX_HOLDING_BYTE}) begin
      next_st.rx_holding_full = 1'b0;
    end
    if (rd && wb_adr_i == {2'b00, ADDR_CRC_RESULT_BYTE}) begin
      next_st.crc_ready_flag = 1'b0;
    end
    if (st.module_enable) begin
      if (start_det_i) begin
        next_st.bus_busy_flag = 1'b1;
        next_st.crc_acc = RST_BYTE;
      end
      if (stop_det_i) begin
        next_st.bus_busy_flag = 1'b0;
      end
      // Address phase
      if (addr_done_i && !st.master_mode) begin
        next_st.own_address_matched = addr_match_i;
        if (addr_match_i) begin
          next_st.slave_direction = addr_read_i;
          next_st.rx_addr = rx_byte_i;
          next_st.hold_tx = 1'b0;
        end
      end
      if (addr_done_i) begin
        next_st.ack_not_received = !ack_seen_i;
      end
      // Data byte complete
      if (byte_done_i) begin
        next_st.ack_not_received = !ack_seen_i;
        if (is_rx_i) begin
          next_st.own_address_matched = 1'b0;
          if (!st.rx_holding_full || (rd && wb_adr_i == {2'b00, ADDR_RX_HOLDING_BYTE})) begin
            next_st.rx_holding_byte = rx_byte_i;
            next_st.rx_holding_full = 1'b1;
            next_st.rx_event_flag = 1'b1;
          end
        end
        if (!ack_seen_i && !is_rx_i && !st.master_mode) begin
          next_st.hold_tx = 1'b1;
        end
        if (!ack_seen_i && !is_rx_i && st.master_mode) begin
          next_st.gen_stop = 1'b1;
        end
        // CRC per byte; overwrite also sets the ready flag again
        next_st.crc_acc = crc_next;
        next_st.crc_result_byte = crc_next;
        next_st.crc_ready_flag = 1'b1;
      end
      if (handoff) begin
        next_st.shift_load = 1'b1;
        next_st.shift_byte = st.tx_holding_byte;
        next_st.tx_holding_empty = 1'b1;
        next_st.tx_event_flag = 1'b1;
      end
      if (st.master_mode && arb_lost_i) begin
        next_st.master_mode = 1'b0;
        next_st.arb_lost = 1'b1;
        next_st.release_lines = 1'b1;
      end else if (start_det_i) begin
        next_st.release_lines = 1'b0;
      end
    end else begin
      next_st.bus_busy_flag = 1'b0;
      next_st.release_lines = 1'b1;
      next_st.tx_event_flag = 1'b0;
      next_st.rx_event_flag = 1'b0;
      next_st.master_mode = wr && wb_adr_i == ADDR_CONTROL && wb_dat_i[CTL_MASTER_BIT];
    end
    if (st.module_enable && !next_st.module_enable) begin
      next_st.release_lines = 1'b1;
    end else if (!st.module_enable && next_st.module_enable) begin
      next_st.release_lines = 1'b0;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
      st.tx_holding_empty <= 1'b1;
      st.ack_not_received <= 1'b1;
      st.release_lines <= 1'b1;
      st.divider_select <= RST_DIV_SEL;
    end else begin
      st <= next_st;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign wb_ack_o = st.ack;
  assign wb_dat_o = st.rdata;
  assign shift_load_o = st.shift_load;
  assign shift_byte_o = st.shift_byte;
  assign gen_stop_o = st.gen_stop;
  assign sda_release_o = st.release_lines || st.hold_tx;
  assign scl_release_o = st.release_lines;

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  slave_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st.module_enable && !st.master_mode && !st.tx_holding_empty && addr_done_i
    && addr_match_i && addr_read_i |=> shift_load_o && st.tx_holding_empty)
    else $error("Slave read did not load");
  nack_hold_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st.module_enable && !st.master_mode && byte_done_i && !is_rx_i && !ack_seen_i
    |=> sda_release_o) else $error("Nack did not release SDA");
  master_load_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st.module_enable && st.master_mode && !st.master_direction && !st.tx_holding_empty
    && addr_done_i && ack_seen_i && !arb_lost_i |=> shift_load_o)
    else $error("Master write did not load");
  master_nack_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st.module_enable && st.master_mode && byte_done_i && !is_rx_i && !ack_seen_i
    && !addr_done_i |=> gen_stop_o && !shift_load_o) else $error("Master nack wrong");
  rx_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && wb_adr_i == {2'b00, ADDR_RX_HOLDING_BYTE} && !byte_done_i
    |=> !st.rx_holding_full) else $error("Receive full not cleared");
  rx_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
    $rose(st.rx_holding_full) |-> st.rx_event_flag) else $error("No receive event");
  crc_set_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st.module_enable && byte_done_i |=> st.crc_ready_flag && st.crc_result_byte == st.crc_acc)
    else $error("CRC not loaded");
  crc_clear_a: assert property (@(posedge clk_i) disable iff (rst_i)
    rd && wb_adr_i == {2'b00, ADDR_CRC_RESULT_BYTE} && !(st.module_enable && byte_done_i)
    |=> !st.crc_ready_flag) else $error("CRC ready not cleared");
  arb_rel_a: assert property (@(posedge clk_i) disable iff (rst_i)
    st.module_enable && st.master_mode && arb_lost_i
    |=> sda_release_o && scl_release_o && !st.master_mode) else $error("No release");
  disable_a: assert property (@(posedge clk_i) disable iff (rst_i)
    !st.module_enable |=> !st.bus_busy_flag) else $error("Busy not cleared");
  tx_event_a: assert property (@(posedge clk_i) disable iff (rst_i)
    handoff |=> st.tx_event_flag && st.tx_holding_empty) else $error("No tx event");

  slave_tx_c: cover property (@(posedge clk_i) disable iff (rst_i) handoff && !st.master_mode);
  master_tx_c: cover property (@(posedge clk_i) disable iff (rst_i) handoff && st.master_mode);
  rx_byte_c: cover property (@(posedge clk_i) disable iff (rst_i) $rose(st.rx_holding_full));
  arb_c: cover property (@(posedge clk_i) disable iff (rst_i) st.master_mode && arb_lost_i);

endmodule
`default_nettype wire

// *** rtl/mmtw_pkg.sv ***
// Package: register map, field layout, reset values and timing for the two-wire data path
package mmtw_pkg;

  // Register word offsets (byte addresses)
  localparam logic [3:0] ADDR_TX_HOLDING_BYTE = 4'h0;
  localparam logic [3:0] ADDR_RX_HOLDING_BYTE = 4'h4;
  localparam logic [3:0] ADDR_CRC_RESULT_BYTE = 4'h8;
  localparam logic [3:0] ADDR_BIT_RATE_DIVIDER = 4'hc;

  // Control and status word offsets (chosen)
  localparam logic [5:0] ADDR_CONTROL = 6'h10;
  localparam logic [5:0] ADDR_STATUS = 6'h14;

  // Control field positions
  localparam int CTL_ENABLE_BIT = 0;
  localparam int CTL_MASTER_BIT = 1;
  localparam int CTL_DIR_BIT = 2;

  // Status field positions
  localparam int ST_TX_EMPTY_BIT = 0;
  localparam int ST_RX_FULL_BIT = 1;
  localparam int ST_TX_EVENT_BIT = 2;
  localparam int ST_RX_EVENT_BIT = 3;
  localparam int ST_CRC_READY_BIT = 4;
  localparam int ST_BUSY_BIT = 5;
  localparam int ST_MATCH_BIT = 6;
  localparam int ST_SLAVE_DIR_BIT = 7;
  localparam int ST_NACK_BIT = 8;
  localparam int ST_ARB_LOST_BIT = 9;

  // Reset values
  localparam logic [7:0] RST_BYTE = 8'h00;
  localparam logic [2:0] RST_DIV_SEL = 3'h0;

  // Divider base figure and CRC polynomial (x^8+x^2+x+1)
  localparam int BASE_DIVISOR = 20;
  localparam logic [7:0] CRC_POLY = 8'h07;

  // Bit-rate window for software guidance, in kHz
  localparam int MIN_RATE_KHZ = 10;
  localparam int MAX_RATE_KHZ = 100;
  localparam int CLK_KHZ = 25000;

  // Shifter sequencing states
  typedef enum logic [1:0] {
    SH_IDLE = 2'b00,
    SH_SHIFT = 2'b01,
    SH_ACK = 2'b11
  } mmtw_sh_t;

endpackage

// *** rtl/mmtw_rate_div.sv ***
// Bit-rate enable generator with eight selectable divisors
`timescale 1ns/1ps
`default_nettype none
module mmtw_rate_div
  import mmtw_pkg::*;
#(
  parameter int CNT_W = 12
) (
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_i,
  // Control
  input wire logic run_i,
  input wire logic [2:0] sel_i,
  // Enable pulse
  output logic tick_o
);

  typedef struct packed {
    logic [CNT_W-1:0] cnt;
    logic tick;
  } mmtw_div_st_t;

  mmtw_div_st_t st;
  mmtw_div_st_t next_st;
  logic [CNT_W-1:0] limit;

  // Divisor 20 << code
  assign limit = CNT_W'((BASE_DIVISOR << sel_i) - 1);

  always_comb begin
    next_st = st;
    next_st.tick = 1'b0;
    if (!run_i) begin
      next_st.cnt = '0;
    end else if (st.cnt >= limit) begin
      next_st.cnt = '0;
      next_st.tick = 1'b1;
    end else begin
      next_st.cnt = st.cnt + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      st <= '0;
    end else begin
      st <= next_st;
    end
  end

  assign tick_o = st.tick;

  period_a: assert property (@(posedge clk_i) disable iff (rst_i)
    tick_o && run_i |=> !tick_o [*8]) else $error("Divider tick too frequent");

endmodule
`default_nettype wire
